// file: txbcs_regs.vh
`ifndef TXBCS_REGS_VH
`define TXBCS_REGS_VH

// Character type codes produced per channel.
`define TXBCS_CHAR_DATA 2'h0
`define TXBCS_CHAR_FILL 2'h1
`define TXBCS_CHAR_SPECIAL 2'h2
`define TXBCS_CHAR_WSYNC 2'h3

// Bonding selection codes.
`define TXBCS_BOND_NONE 2'h0
`define TXBCS_BOND_DUAL 2'h1
`define TXBCS_BOND_QUAD 2'h2

// APB register byte offsets.
`define TXBCS_OFF_CTRL 12'h000
`define TXBCS_OFF_STATUS 12'h004
`define TXBCS_OFF_CHAR 12'h008
`define TXBCS_OFF_FIFO 12'h00C

// Control register fields.
`define TXBCS_CTRL_BOND_LSB 0
`define TXBCS_CTRL_LOOP_BIT 2
`define TXBCS_CTRL_RESET 32'h0000_0000

// Status register fields.
`define TXBCS_STAT_OE_LSB 0
`define TXBCS_STAT_TP_LSB 8
`define TXBCS_STAT_RX_LSB 16
`define TXBCS_STAT_PD_LSB 20

// Resting value of the test-pattern latch: all generators disabled.
`define TXBCS_TP_RESET 8'hFF

`endif

// file: txbcs_fifo.v
`timescale 1ns/1ps
`default_nettype none

module txbcs_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // Clock and reset.
    input wire ref_clk,
    input wire rst,
    // Fill side.
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // Drain side.
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    reg [AW:0] count_r;
    wire push;
    wire pop;

    assign in_ready = (count_r != DEPTH[AW:0]);
    assign out_valid = (count_r != {(AW+1){1'b0}});
    assign out_data = mem_r[rd_ptr_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always @(posedge ref_clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule // txbcs_fifo

`default_nettype wire

// file: txbcs_top.v
// What this block does
// - Dual-bonded with char_ctl_b[0] low, channel A picks data, fill, special or sync from char_ctl_a[1:0].
// - Dual-bonded with char_ctl_b[0] low, channel B uses char_ctl_b[1] with char_ctl_a[0].
// - Dual-bonded, char_ctl_b[0] high starts word sync on channels A and B regardless of other bits.
// - Dual-bonded with char_ctl_d[0] low, C uses char_ctl_c[1:0] and D uses char_ctl_d[1] with char_ctl_c[0].
// - Dual-bonded, char_ctl_d[0] high starts word sync on channels C and D.
// - Quad-bonded with char_ctl_b[0] low, each channel uses its bit 1 with char_ctl_a[0]; C and D bit 0 ignored.
// - Quad-bonded, char_ctl_b[0] high starts word sync on all four channels.
// - Local loopback forces every enabled driver to a constant logic one.
// - The output-enable latch is transparent while its control is high; a high bit enables its driver, a low bit disables it.
// - A channel whose two drivers are both disabled has its transmit logic powered down.
// - The falling edge of the output-enable control captures the enable bits until the control rises again.
// - Device reset low clears the output-enable latch, disabling all drivers.
// - Enable bits 7..0 map to D2,D1,C2,C1,B2,B1,A2,A1; odd bits are transmit and even bits receive test enables; even bits are receive enables.
// - The test-pattern latch is transparent while its control is high, a low bit enables, it holds on fall, and reset disables all.
// - The bonding select picks no bonding, dual pairs A-B and C-D, or quad bonding of all four.
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "txbcs_regs.vh"

module txbcs_top (
    // Clock and reset.
    input wire ref_clk,
    input wire rst,
    // APB slave.
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Device pins from the host logic.
    input wire [1:0] char_ctl_a,
    input wire [1:0] char_ctl_b,
    input wire [1:0] char_ctl_c,
    input wire [1:0] char_ctl_d,
    input wire [7:0] shared_enable_bus,
    input wire output_enable_latch_ctl,
    input wire test_pattern_latch_ctl,
    input wire receive_enable_latch_ctl,
    input wire device_reset_n,
    // Per-channel character types, channel A in the low bits.
    output reg [7:0] char_type,
    // Serial driver enables and their forced level.
    output reg [7:0] serial_out_driver_en,
    output reg [7:0] serial_out_driver_force_one,
    output reg [3:0] tx_logic_power_down,
    // Test-pattern and receive enables, active high.
    output reg [7:0] built_in_pattern_test_en,
    output reg [3:0] receive_channel_en
);
    // Synchronised pins.
    reg [15:0] pin_s1_r;
    reg [15:0] pin_s2_r;
    reg [3:0] ctl_s1_r;
    reg [3:0] ctl_s2_r;
    wire [1:0] cta;
    wire [1:0] ctb;
    wire [1:0] ctc;
    wire [1:0] ctd;
    wire [7:0] ebus;
    wire oe_le;
    wire tp_le;
    wire rx_le;
    wire dev_rst_n;

    // Software state, enable latches and next character types.
    reg [1:0] receive_bonding_select_r;
    reg local_loopback_r;
    reg [7:0] oe_latch_r;
    reg [7:0] tp_latch_r;
    reg [3:0] rx_latch_r;
    reg [7:0] char_type_nxt;

    // Character history FIFO.
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [7:0] fifo_out_data;
    reg fifo_pop;
    reg [7:0] char_prev_r;
    reg char_seen_r;
    wire fifo_push;

    // APB.
    wire apb_access;
    wire apb_wr;
    reg [31:0] rdata_nxt;
    reg addr_ok;

    assign cta = pin_s2_r[1:0];
    assign ctb = pin_s2_r[3:2];
    assign ctc = pin_s2_r[5:4];
    assign ctd = pin_s2_r[7:6];
    assign ebus = pin_s2_r[15:8];
    assign oe_le = ctl_s2_r[0];
    assign tp_le = ctl_s2_r[1];
    assign rx_le = ctl_s2_r[2];
    assign dev_rst_n = ctl_s2_r[3];

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_s1_r <= 16'h0000;
            pin_s2_r <= 16'h0000;
            ctl_s1_r <= 4'h8;
            ctl_s2_r <= 4'h8;
        end else begin
            pin_s1_r <= {shared_enable_bus, char_ctl_d, char_ctl_c, char_ctl_b, char_ctl_a};
            pin_s2_r <= pin_s1_r;
            ctl_s1_r <= {device_reset_n, receive_enable_latch_ctl, test_pattern_latch_ctl,
                         output_enable_latch_ctl};
            ctl_s2_r <= ctl_s1_r;
        end
    end

    // Character type mapping for every bonding mode.
    always @* begin
        char_type_nxt = {ctd, ctc, ctb, cta};
        case (receive_bonding_select_r)
            `TXBCS_BOND_DUAL: begin
                if (ctb[0]) begin
                    char_type_nxt[3:0] = {`TXBCS_CHAR_WSYNC, `TXBCS_CHAR_WSYNC};
                end else begin
                    char_type_nxt[1:0] = cta;
                    char_type_nxt[3:2] = {ctb[1], cta[0]};
                end
                if (ctd[0]) begin
                    char_type_nxt[7:4] = {`TXBCS_CHAR_WSYNC, `TXBCS_CHAR_WSYNC};
                end else begin
                    char_type_nxt[7:4] = {ctd[1], ctc[0], ctc};
                end
            end
            `TXBCS_BOND_QUAD: begin
                if (ctb[0]) begin
                    char_type_nxt = {4{`TXBCS_CHAR_WSYNC}};
                end else begin
                    char_type_nxt = {ctd[1], cta[0], ctc[1], cta[0],
                                     ctb[1], cta[0], cta};
                end
            end
            default: begin
                char_type_nxt = {ctd, ctc, ctb, cta};
            end
        endcase
    end

    // The first generated character pattern after reset is logged, then each pattern that differs from the last one logged, once the log has room.
    assign fifo_push = !char_seen_r || (char_type_nxt != char_prev_r);

    txbcs_fifo #(
        .WIDTH(8),
        .DEPTH(8),
        .AW(3)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data(char_type_nxt),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // Enable latches and outputs.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            oe_latch_r <= 8'h00;
            tp_latch_r <= `TXBCS_TP_RESET;
            rx_latch_r <= 4'h0;
            char_type <= 8'h00;
            char_prev_r <= 8'h00;
            char_seen_r <= 1'b0;
            serial_out_driver_en <= 8'h00;
            serial_out_driver_force_one <= 8'h00;
            tx_logic_power_down <= 4'hF;
            built_in_pattern_test_en <= 8'h00;
            receive_channel_en <= 4'h0;
        end else begin
            if (!dev_rst_n) begin
                oe_latch_r <= 8'h00;
                tp_latch_r <= `TXBCS_TP_RESET;
                rx_latch_r <= 4'h0;
            end else begin
                if (oe_le) begin
                    oe_latch_r <= ebus;
                end
                if (tp_le) begin
                    tp_latch_r <= ebus;
                end
                if (rx_le) begin
                    rx_latch_r <= {ebus[6], ebus[4], ebus[2], ebus[0]};
                end
            end
            if (fifo_in_ready) begin
                char_type <= char_type_nxt;
                char_prev_r <= char_type_nxt;
                char_seen_r <= 1'b1;
            end
            serial_out_driver_en <= oe_latch_r;
            serial_out_driver_force_one <= local_loopback_r ? oe_latch_r : 8'h00;
            tx_logic_power_down <= {oe_latch_r[7:6] == 2'b00, oe_latch_r[5:4] == 2'b00,
                                    oe_latch_r[3:2] == 2'b00,
                                    oe_latch_r[1:0] == 2'b00};
            built_in_pattern_test_en <= ~tp_latch_r;
            receive_channel_en <= rx_latch_r;
        end
    end

    // APB slave: access phase with one wait state.
    assign apb_access = psel && penable && !pready;
    assign apb_wr = apb_access && pwrite;

    always @* begin
        addr_ok = 1'b1;
        rdata_nxt = 32'h0000_0000;
        fifo_pop = 1'b0;
        case (paddr)
            `TXBCS_OFF_CTRL: begin
                rdata_nxt[`TXBCS_CTRL_BOND_LSB+1:`TXBCS_CTRL_BOND_LSB] = receive_bonding_select_r;
                rdata_nxt[`TXBCS_CTRL_LOOP_BIT] = local_loopback_r;
            end
            `TXBCS_OFF_STATUS: begin
                rdata_nxt[`TXBCS_STAT_OE_LSB+7:`TXBCS_STAT_OE_LSB] = oe_latch_r;
                rdata_nxt[`TXBCS_STAT_TP_LSB+7:`TXBCS_STAT_TP_LSB] = tp_latch_r;
                rdata_nxt[`TXBCS_STAT_RX_LSB+3:`TXBCS_STAT_RX_LSB] = rx_latch_r;
                rdata_nxt[`TXBCS_STAT_PD_LSB+3:`TXBCS_STAT_PD_LSB] = tx_logic_power_down;
            end
            `TXBCS_OFF_CHAR: begin
                rdata_nxt[7:0] = char_type;
            end
            `TXBCS_OFF_FIFO: begin
                rdata_nxt[7:0] = fifo_out_data;
                rdata_nxt[8] = fifo_out_valid;
                fifo_pop = apb_access && !pwrite && fifo_out_valid;
            end
            default: begin
                addr_ok = 1'b0;
            end
        endcase
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            receive_bonding_select_r <= `TXBCS_BOND_NONE;
            local_loopback_r <= 1'b0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= apb_access;
            pslverr <= apb_access && !addr_ok;
            if (apb_access && !pwrite) begin
                prdata <= rdata_nxt;
            end
            if (apb_wr && paddr == `TXBCS_OFF_CTRL) begin
                receive_bonding_select_r <= pwdata[`TXBCS_CTRL_BOND_LSB+1:`TXBCS_CTRL_BOND_LSB];
                local_loopback_r <= pwdata[`TXBCS_CTRL_LOOP_BIT];
            end
        end
    end
endmodule // txbcs_top

`default_nettype wire

// file: txbcs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module txbcs_host_model (
    // Clock.
    input wire logic ref_clk,
    // Requested controls, channel A in the low bits.
    input wire logic [7:0] code,
    // Controls toward the device.
    output logic [1:0] char_ctl_a,
    output logic [1:0] char_ctl_b,
    output logic [1:0] char_ctl_c,
    output logic [1:0] char_ctl_d
);
    // All four pairs launch on one edge so bonded pair bits never skew.
    always @(posedge ref_clk) begin
        {char_ctl_d, char_ctl_c, char_ctl_b, char_ctl_a} <= code;
    end
endmodule // txbcs_host_model
`default_nettype wire

// file: txbcs_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module txbcs_mon (
    // Clock, reset and bus.
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    // Enable pins.
    input wire logic [7:0] shared_enable_bus,
    input wire logic output_enable_latch_ctl,
    input wire logic test_pattern_latch_ctl,
    input wire logic receive_enable_latch_ctl,
    input wire logic device_reset_n,
    // Driver side.
    input wire logic [7:0] serial_out_driver_en,
    input wire logic [7:0] serial_out_driver_force_one,
    input wire logic [3:0] tx_logic_power_down,
    input wire logic [7:0] built_in_pattern_test_en,
    input wire logic [3:0] receive_channel_en
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_open(ctl);
        (ctl && device_reset_n && $stable(shared_enable_bus))[*5];
    endsequence
    sequence s_shut;
        (!output_enable_latch_ctl && device_reset_n)[*5];
    endsequence
    ready_answer_a: assert property (psel && penable && !pready |=> pready)
        else $error("no answer after one wait state");
    force_enabled_a: assert property ((serial_out_driver_force_one & ~serial_out_driver_en) == 8'h00)
        else $error("disabled driver forced");
    power_down_a: assert property (tx_logic_power_down == {~|serial_out_driver_en[7:6],
        ~|serial_out_driver_en[5:4], ~|serial_out_driver_en[3:2], ~|serial_out_driver_en[1:0]})
        else $error("power down does not match enables");
    oe_follow_a: assert property (s_open(output_enable_latch_ctl) |=> serial_out_driver_en == shared_enable_bus)
        else $error("open enable latch not following bus");
    oe_hold_a: assert property (s_shut |=> $stable(serial_out_driver_en))
        else $error("closed enable latch moved");
    tp_follow_a: assert property (s_open(test_pattern_latch_ctl) |=> built_in_pattern_test_en == ~shared_enable_bus)
        else $error("test enable not inverse of bus");
    rx_follow_a: assert property (s_open(receive_enable_latch_ctl) |=> receive_channel_en ==
        {shared_enable_bus[6], shared_enable_bus[4], shared_enable_bus[2], shared_enable_bus[0]})
        else $error("receive enables not from even bits");
    dev_reset_a: assert property ((!device_reset_n)[*4] |=> serial_out_driver_en == 8'h00)
        else $error("device reset left a driver on");
endmodule // txbcs_mon
`default_nettype wire

// file: tb_txbcs_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "txbcs_regs.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_txbcs_top;
    logic ref_clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic output_enable_latch_ctl = 1'h0, test_pattern_latch_ctl = 1'h0;
    logic receive_enable_latch_ctl = 1'h0, device_reset_n = 1'h1, pready, pslverr, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [7:0] shared_enable_bus = 8'h00, code = 8'h00, char_type, serial_out_driver_en;
    logic [7:0] serial_out_driver_force_one, built_in_pattern_test_en;
    logic [3:0] tx_logic_power_down, receive_channel_en;
    logic [1:0] char_ctl_a, char_ctl_b, char_ctl_c, char_ctl_d;
    integer error_cnt = 0, cmp_count = 0, i, m;
    txbcs_top i_dut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .char_ctl_a, .char_ctl_b, .char_ctl_c, .char_ctl_d, .shared_enable_bus,
        .output_enable_latch_ctl, .test_pattern_latch_ctl, .receive_enable_latch_ctl,
        .device_reset_n, .char_type, .serial_out_driver_en, .serial_out_driver_force_one,
        .tx_logic_power_down, .built_in_pattern_test_en, .receive_channel_en);
    txbcs_host_model i_host (.ref_clk, .code, .char_ctl_a, .char_ctl_b, .char_ctl_c, .char_ctl_d);
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    task finish_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task tick(input integer n);
        repeat (n) @(posedge ref_clk);
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        integer n;
        begin
            @(posedge ref_clk);
            psel <= 1'h1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= d;
            @(posedge ref_clk);
            penable <= 1'h1;
            n = 0;
            do begin
                @(posedge ref_clk);
                n = n + 1;
            end while (pready !== 1'h1 && n < 20);
            rd = prdata;
            err = pslverr;
            psel <= 1'h0;
            penable <= 1'h0;
            if (n >= 20) begin
                error_cnt++;
                finish_test;
            end
        end
    endtask
    task latch(input integer which, input logic [7:0] v);
        @(posedge ref_clk);
        shared_enable_bus <= v;
        output_enable_latch_ctl <= (which == 0);
        test_pattern_latch_ctl <= (which == 1);
        receive_enable_latch_ctl <= (which == 2);
        tick(8);
        output_enable_latch_ctl <= 1'h0;
        test_pattern_latch_ctl <= 1'h0;
        receive_enable_latch_ctl <= 1'h0;
        tick(6);
    endtask
    task put(input logic [7:0] v);
        @(posedge ref_clk);
        code <= v;
        tick(6);
    endtask
    // Pops the log until it reports empty, so a full log no longer holds the character output frozen.
    task drain;
        integer n;
        begin
            n = 0;
            do begin
                apb(1'h0, `TXBCS_OFF_FIFO, 32'h0000_0000);
                n = n + 1;
            end while (rd[8] === 1'h1 && n < 20);
            if (n >= 20) begin
                error_cnt++;
                finish_test;
            end
        end
    endtask
    function automatic logic [7:0] exp_char(input logic [1:0] md, input logic [7:0] c);
        logic [1:0] w;
        begin
            w = `TXBCS_CHAR_WSYNC;
            if (md == `TXBCS_BOND_DUAL) begin
                exp_char = {c[6] ? w : {c[7], c[4]}, c[6] ? w : c[5:4],
                    c[2] ? w : {c[3], c[0]}, c[2] ? w : c[1:0]};
            end else if (md == `TXBCS_BOND_QUAD) begin
                exp_char = c[2] ? {4{w}} : {c[7], c[0], c[5], c[0], c[3], c[0], c[1:0]};
            end else begin
                exp_char = c;
            end
        end
    endfunction
    initial begin
        tick(4);
        rst <= 1'h0;
        apb(1'h0, `TXBCS_OFF_CTRL, 32'h0000_0000);
        `CHK(rd, `TXBCS_CTRL_RESET)
        apb(1'h0, `TXBCS_OFF_STATUS, 32'h0000_0000);
        `CHK(rd, 32'h00F0_FF00)
        apb(1'h0, 12'h010, 32'h0000_0000);
        `CHK({err, rd}, {1'h1, 32'h0000_0000})
        apb(1'h1, 12'h010, 32'hFFFF_FFFF);
        `CHK(err, 1'h1)
        $display("Reset and map test done");
        latch(0, 8'hC9);
        `CHK(serial_out_driver_en, 8'hC9)
        `CHK(tx_logic_power_down, 4'h4)
        latch(1, 8'h36);
        `CHK(serial_out_driver_en, 8'hC9)
        `CHK(built_in_pattern_test_en, 8'hC9)
        latch(2, 8'h36);
        `CHK(receive_channel_en, 4'h6)
        apb(1'h1, `TXBCS_OFF_CTRL, 32'h0000_0004);
        apb(1'h0, `TXBCS_OFF_CTRL, 32'h0000_0000);
        `CHK(rd, 32'h0000_0004)
        tick(4);
        `CHK(serial_out_driver_force_one, 8'hC9)
        apb(1'h1, `TXBCS_OFF_CTRL, 32'h0000_0000);
        tick(4);
        `CHK(serial_out_driver_force_one, 8'h00)
        $display("Latch and loopback test done");
        for (m = 0; m < 4; m++) begin
            apb(1'h1, `TXBCS_OFF_CTRL, 32'(m));
            for (i = 0; i < 256; i++) begin
                put(i[7:0]);
                `CHK(char_type, exp_char(m[1:0], i[7:0]))
                drain;
            end
        end
        $display("Character map test done");
        apb(1'h1, `TXBCS_OFF_CTRL, 32'h0000_0000);
        tick(6);
        drain;
        for (i = 1; i <= 10; i++) begin
            put(i[7:0]);
        end
        `CHK(char_type == 8'h0A, 1'h0)
        apb(1'h0, `TXBCS_OFF_FIFO, 32'h0000_0000);
        `CHK(rd[8:0], 9'h101)
        drain;
        tick(6);
        `CHK(char_type, 8'h0A)
        apb(1'h0, `TXBCS_OFF_CHAR, 32'h0000_0000);
        `CHK(rd, 32'h0000_000A)
        $display("Buffer test done");
        @(posedge ref_clk);
        device_reset_n <= 1'h0;
        tick(6);
        `CHK({serial_out_driver_en, built_in_pattern_test_en, receive_channel_en, tx_logic_power_down}, 24'h00_000F)
        device_reset_n <= 1'h1;
        $display("Device reset test done");
        finish_test;
    end
endmodule // tb_txbcs_top
bind txbcs_top txbcs_mon i_mon (.ref_clk, .rst, .psel, .penable, .pready, .shared_enable_bus,
    .output_enable_latch_ctl, .test_pattern_latch_ctl, .receive_enable_latch_ctl,
    .device_reset_n, .serial_out_driver_en, .serial_out_driver_force_one,
    .tx_logic_power_down, .built_in_pattern_test_en, .receive_channel_en);
`default_nettype wire
